// file: src/edgc_pkg.sv
// Package of the energy detect and gain control block: register map,
// reset values, field positions, timing figures and shared types.
// Assumes a 20 MHz core clock.
package edgc_pkg;

    // Register offsets on the host register port
    localparam logic [7:0] OFS_ENERGY_RESULT = 8'h16;
    localparam logic [7:0] OFS_IDLE_WAIT_LOW = 8'h17;
    localparam logic [7:0] OFS_IDLE_WAIT_HIGH = 8'h18;
    localparam logic [7:0] OFS_IDLE_ELAPSED_LOW = 8'h19;
    localparam logic [7:0] OFS_IDLE_ELAPSED_HIGH = 8'h1A;
    localparam logic [7:0] OFS_ENERGY_CONTROL = 8'h1B;
    localparam logic [7:0] OFS_GAIN_MID_TO_LOW = 8'h1C;
    localparam logic [7:0] OFS_GAIN_LOW_TO_MID = 8'h1D;
    localparam logic [7:0] OFS_GAIN_HIGH_TO_MID = 8'h1E;
    localparam logic [7:0] OFS_GAIN_MID_TO_HIGH = 8'h1F;
    localparam logic [7:0] OFS_OFFSET_MIDDLE = 8'h20;
    localparam logic [7:0] OFS_OFFSET_LOW = 8'h21;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_ENERGY_CONTROL = 8'h83;
    localparam logic [7:0] RST_GAIN_MID_TO_LOW = 8'h1E;
    localparam logic [7:0] RST_GAIN_LOW_TO_MID = 8'h03;
    localparam logic [7:0] RST_GAIN_HIGH_TO_MID = 8'h9E;
    localparam logic [7:0] RST_GAIN_MID_TO_HIGH = 8'h03;
    localparam logic [7:0] RST_OFFSET_MIDDLE = 8'h19;
    localparam logic [7:0] RST_OFFSET_LOW = 8'h37;

    // Field positions
    localparam int BIT_CALC_ON = 7;
    localparam int BIT_CALC_COMPLETE = 4;
    localparam int BIT_FREEZE_ON_SYNC = 7;
    localparam int AVG_MSB = 2;
    localparam int THR_MSB = 5;
    localparam int WAIT_HIGH_MSB = 1;

    // Averaging codes and sample counts
    localparam logic [2:0] AVG_CODE_1 = 3'h0;
    localparam logic [2:0] AVG_CODE_2 = 3'h1;
    localparam logic [2:0] AVG_CODE_4 = 3'h2;
    localparam logic [2:0] AVG_CODE_8 = 3'h3;
    localparam logic [2:0] AVG_CODE_15 = 3'h4;
    localparam logic [2:0] AVG_CODE_16 = 3'h5;
    localparam logic [4:0] AVG_DEFAULT_SAMPLES = 5'h08;
    localparam logic [4:0] AVG_ODD_SAMPLES = 5'h0F;

    // Assessment result codes
    localparam logic [1:0] ASSESS_CLEAR = 2'h0;
    localparam logic [1:0] ASSESS_CARRIER = 2'h1;
    localparam logic [1:0] ASSESS_BUSY = 2'h3;

    // Conversion interval timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int TADC_1M8_NS = 17600;
    localparam int TADC_2M0_NS = 16000;
    localparam int TADC_1M8_CYC = TADC_1M8_NS / CLK_PERIOD_NS;
    localparam int TADC_2M0_CYC = TADC_2M0_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 9;
    localparam logic [10:0] IDLE_AVG_INTERVALS = 11'h008;

    // Gain range, one-hot
    typedef enum logic [2:0] {
        RANGE_HIGH = 3'b001,
        RANGE_MID = 3'b010,
        RANGE_LOW = 3'b100
    } edgc_range_t;

    // Sample handed to the averager
    typedef struct packed {
        logic vld;
        logic [7:0] level;
    } edgc_sample_t;

    // Host register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } edgc_req_t;

    // Number of samples for an averaging code
    function automatic logic [4:0] edgc_avg_samples(input logic [2:0] code);
        unique case (code)
            AVG_CODE_1: return 5'h01;
            AVG_CODE_2: return 5'h02;
            AVG_CODE_4: return 5'h04;
            AVG_CODE_15: return AVG_ODD_SAMPLES;
            AVG_CODE_16: return 5'h10;
            default: return AVG_DEFAULT_SAMPLES;
        endcase
    endfunction : edgc_avg_samples

endpackage : edgc_pkg

// file: src/edgc_averager.sv
// Averager of offset-corrected strength samples for the energy block.
// Assumes the count is held steady while an average is being gathered.
`timescale 1ns/100ps
`default_nettype none
module edgc_averager
    import edgc_pkg::*;
(
    input wire logic core_clk, // 20 MHz clock
    input wire logic rst_b, // Async reset, active low
    input wire logic restart, // Drop partial sum
    input wire edgc_sample_t sample, // Accepted sample
    input wire logic [4:0] samples, // Samples per average
    output logic avg_vld, // One-cycle pulse with new mean
    output logic [7:0] avg // Registered mean
);

    typedef struct packed {
        logic [12:0] sum;
        logic [4:0] taken;
        logic [7:0] avg;
        logic vld;
    } edgc_avg_state_t;

    edgc_avg_state_t s_q, s_d;
    logic [12:0] sum_next;
    logic [12:0] quot;

    // Accumulate, divide when complete
    always_comb begin
        s_d = s_q;
        s_d.vld = 1'b0;
        sum_next = s_q.sum + {5'h00, sample.level};
        unique case (samples)
            5'h01: quot = sum_next;
            5'h02: quot = sum_next >> 1;
            5'h04: quot = sum_next >> 2;
            AVG_ODD_SAMPLES: quot = sum_next / 13'(AVG_ODD_SAMPLES); // Constant divider, no shift
            5'h10: quot = sum_next >> 4;
            default: quot = sum_next >> 3;
        endcase
        if (restart) begin
            s_d.sum = 13'h0000;
            s_d.taken = 5'h00;
        end else if (sample.vld) begin
            if (s_q.taken + 5'h01 >= samples) begin // see RULE19
                s_d.avg = quot[7:0];
                s_d.vld = 1'b1;
                s_d.sum = 13'h0000;
                s_d.taken = 5'h00;
            end else begin
                s_d.sum = sum_next;
                s_d.taken = s_q.taken + 5'h01;
            end
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign avg_vld = s_q.vld;
    assign avg = s_q.avg;

endmodule : edgc_averager
`default_nettype wire

// file: src/edgc_core.sv
// Energy detection and gain range control with its host registers.
// Assumes the host interface decodes serial frames into one-cycle register
// requests, and that RF state, strength and sync come in on core_clk.
//
// Contract
// RULE1: Energy result register refreshes with the averaged value on entering receive.
// RULE2: Idle wait limit is ten bits; time is eight plus setting intervals.
// RULE3: Conversion interval is 17.6 us at 1.8 MHz, 16.0 us at 2.0 MHz.
// RULE4: Elapsed idle time reads as a ten-bit count of conversion intervals.
// RULE5: Calc enable, set at reset, runs energy computation; zero suspends it.
// RULE6: Bit 4 of control reads zero while busy, one once complete.
// RULE7: Averaging code picks 1,2,4,8,15,16 samples; other codes give 8.
// RULE8: Host changes averaging code only while no computation runs.
// RULE9: Freeze bit holds gain after demodulator sync; clear keeps updating.
// RULE10: Host clears freeze bit during bit error rate measurement.
// RULE11: Four six-bit thresholds switch gain among high, middle, low.
// RULE12: Host keeps middle-to-low threshold above low-to-middle.
// RULE13: Host keeps high-to-middle threshold above middle-to-high.
// RULE14: Middle or low range adds its own six-bit offset to strength.
// RULE15: Host waits for state 0x99 after auto assessment before writing.
// RULE16: Host should keep vendor thresholds and offsets.
// RULE17: Energy above assessment threshold reports carrier found, code 01.
// RULE18: Samples above exclusion threshold skip averaging; result shows busy 11.
// RULE19: Energy is mean of corrected samples per interval, then completion flag.
`timescale 1ns/100ps
`default_nettype none
module edgc_core
    import edgc_pkg::*;
#(
    parameter int TADC_SLOW_CYC = TADC_1M8_CYC, // Interval at 1.8 MHz ADC clock
    parameter int TADC_FAST_CYC = TADC_2M0_CYC // Interval at 2.0 MHz ADC clock
) (
    input wire logic core_clk, // 20 MHz clock
    input wire logic rst_b, // Async reset, active low
    input wire edgc_req_t reg_req, // Register request from host interface
    output logic [7:0] reg_rdata, // Read data, one cycle after rd
    input wire logic adc_clk_fast, // 1: 2.0 MHz ADC clock, 0: 1.8 MHz
    input wire logic rx_on, // RF state is receive-on
    input wire logic [7:0] strength_raw, // Raw strength from converter
    input wire logic demod_sync, // Demodulator locked to signal
    input wire logic assess_active, // Channel assessment running
    input wire logic [7:0] assess_threshold, // Carrier threshold
    input wire logic [7:0] exclusion_threshold, // Sample exclusion level
    input wire logic assess_result_clear, // Pulse: host clears result
    output logic [1:0] assess_result, // Assessment result code
    output logic idle_wait_expired, // Idle wait limit reached
    output logic [2:0] gain_range, // One-hot high, mid, low
    output logic [7:0] energy_level // Current energy value
);

    typedef struct packed {
        logic [7:0] energy_result;
        logic [7:0] idle_wait_low;
        logic [7:0] idle_wait_high;
        logic [9:0] idle_elapsed_count;
        logic [7:0] energy_control;
        logic [7:0] gain_mid_to_low_level;
        logic [7:0] gain_low_to_mid_level;
        logic [7:0] gain_high_to_mid_level;
        logic [7:0] gain_mid_to_high_level;
        logic [7:0] strength_offset_middle;
        logic [7:0] strength_offset_low;
        logic energy_calc_complete;
        logic [TICK_W-1:0] tick_cnt;
        edgc_range_t range;
        logic rx_on_seen;
        logic [1:0] assess;
        logic last_idle;
        logic [7:0] rdata;
    } edgc_core_state_t;

    edgc_core_state_t s_q, s_d;

    localparam logic [TICK_W-1:0] TICK_SLOW_LAST = TICK_W'(TADC_SLOW_CYC - 1);
    localparam logic [TICK_W-1:0] TICK_FAST_LAST = TICK_W'(TADC_FAST_CYC - 1);

    logic tick;
    logic computing;
    logic rx_entry;
    logic [8:0] corrected;
    logic [7:0] sample_level;
    logic excluded;
    edgc_sample_t sample;
    logic [4:0] avg_samples;
    logic avg_vld;
    logic [7:0] avg;
    logic [10:0] idle_limit;
    logic [7:0] offset_now;
    logic [7:0] thr_mid_to_low;
    logic [7:0] thr_low_to_mid;
    logic [7:0] thr_high_to_mid;
    logic [7:0] thr_mid_to_high;
    logic gain_freeze_on_sync;
    logic energy_calc_on;

    // Field views of the stored registers
    assign thr_mid_to_low = {2'b00, s_q.gain_mid_to_low_level[THR_MSB:0]};
    assign thr_low_to_mid = {2'b00, s_q.gain_low_to_mid_level[THR_MSB:0]};
    assign thr_high_to_mid = {2'b00, s_q.gain_high_to_mid_level[THR_MSB:0]};
    assign thr_mid_to_high = {2'b00, s_q.gain_mid_to_high_level[THR_MSB:0]};
    assign gain_freeze_on_sync = s_q.gain_high_to_mid_level[BIT_FREEZE_ON_SYNC];
    assign energy_calc_on = s_q.energy_control[BIT_CALC_ON];
    assign avg_samples = edgc_avg_samples(s_q.energy_control[AVG_MSB:0]); // see RULE7

    // Conversion interval strobe from the selected ADC clock rate
    assign tick = adc_clk_fast ? (s_q.tick_cnt >= TICK_FAST_LAST)
                               : (s_q.tick_cnt >= TICK_SLOW_LAST); // see RULE3

    // Computation runs only in receive with calc enabled
    assign computing = rx_on && energy_calc_on; // see RULE5
    assign rx_entry = rx_on && !s_q.rx_on_seen;

    // Offset by active range; high range needs no correction
    always_comb begin
        unique case (s_q.range)
            RANGE_MID: offset_now = {2'b00, s_q.strength_offset_middle[THR_MSB:0]}; // see RULE14
            RANGE_LOW: offset_now = {2'b00, s_q.strength_offset_low[THR_MSB:0]}; // see RULE14
            default: offset_now = 8'h00;
        endcase
    end

    // Saturate so a strong signal never wraps to a weak reading
    assign corrected = {1'b0, strength_raw} + {1'b0, offset_now};
    assign sample_level = corrected[8] ? 8'hFF : corrected[7:0];
    assign excluded = sample_level > exclusion_threshold; // see RULE18
    assign sample.vld = tick && computing && !excluded; // see RULE18
    assign sample.level = sample_level;

    // Idle wait limit: eight conversion intervals plus the setting
    assign idle_limit = IDLE_AVG_INTERVALS
                      + {1'b0, s_q.idle_wait_high[WAIT_HIGH_MSB:0], s_q.idle_wait_low}; // see RULE2

    edgc_averager edgc_averager_i (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .restart(rx_entry || !computing),
        .sample(sample),
        .samples(avg_samples),
        .avg_vld(avg_vld),
        .avg(avg)
    );

    // Next state of the whole block
    always_comb begin
        s_d = s_q;
        s_d.rx_on_seen = rx_on;
        s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + TICK_W'(1);

        // Host writes; read-only ones ignored
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                OFS_IDLE_WAIT_LOW: s_d.idle_wait_low = reg_req.wdata;
                OFS_IDLE_WAIT_HIGH: s_d.idle_wait_high = reg_req.wdata;
                OFS_ENERGY_CONTROL: s_d.energy_control = reg_req.wdata;
                OFS_GAIN_MID_TO_LOW: s_d.gain_mid_to_low_level = reg_req.wdata;
                OFS_GAIN_LOW_TO_MID: s_d.gain_low_to_mid_level = reg_req.wdata;
                OFS_GAIN_HIGH_TO_MID: s_d.gain_high_to_mid_level = reg_req.wdata;
                OFS_GAIN_MID_TO_HIGH: s_d.gain_mid_to_high_level = reg_req.wdata;
                OFS_OFFSET_MIDDLE: s_d.strength_offset_middle = reg_req.wdata;
                OFS_OFFSET_LOW: s_d.strength_offset_low = reg_req.wdata;
                default: ;
            endcase
        end

        // Host reads, unmapped give zero
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                OFS_ENERGY_RESULT: s_d.rdata = s_q.energy_result;
                OFS_IDLE_WAIT_LOW: s_d.rdata = s_q.idle_wait_low;
                OFS_IDLE_WAIT_HIGH: s_d.rdata = s_q.idle_wait_high;
                OFS_IDLE_ELAPSED_LOW: s_d.rdata = s_q.idle_elapsed_count[7:0]; // see RULE4
                OFS_IDLE_ELAPSED_HIGH: s_d.rdata = {6'h00, s_q.idle_elapsed_count[9:8]}; // see RULE4
                OFS_ENERGY_CONTROL: begin
                    s_d.rdata = s_q.energy_control;
                    s_d.rdata[BIT_CALC_COMPLETE] = s_q.energy_calc_complete; // see RULE6
                end
                OFS_GAIN_MID_TO_LOW: s_d.rdata = s_q.gain_mid_to_low_level;
                OFS_GAIN_LOW_TO_MID: s_d.rdata = s_q.gain_low_to_mid_level;
                OFS_GAIN_HIGH_TO_MID: s_d.rdata = s_q.gain_high_to_mid_level;
                OFS_GAIN_MID_TO_HIGH: s_d.rdata = s_q.gain_mid_to_high_level;
                OFS_OFFSET_MIDDLE: s_d.rdata = s_q.strength_offset_middle;
                OFS_OFFSET_LOW: s_d.rdata = s_q.strength_offset_low;
                default: s_d.rdata = 8'h00;
            endcase
        end

        // Gain moves per interval unless frozen
        if (tick && !(gain_freeze_on_sync && demod_sync)) begin // see RULE9
            unique case (s_q.range)
                RANGE_HIGH: begin
                    if (strength_raw > thr_high_to_mid) s_d.range = RANGE_MID; // see RULE11
                end
                RANGE_MID: begin
                    if (strength_raw > thr_mid_to_low) begin
                        s_d.range = RANGE_LOW; // see RULE11
                    end else if (strength_raw < thr_mid_to_high) begin
                        s_d.range = RANGE_HIGH; // see RULE11
                    end
                end
                RANGE_LOW: begin
                    if (strength_raw < thr_low_to_mid) s_d.range = RANGE_MID; // see RULE11
                end
                default: s_d.range = RANGE_HIGH;
            endcase
        end

        // Completion: busy from receive entry to a mean
        if (rx_entry || !computing) begin
            s_d.energy_calc_complete = 1'b0; // see RULE6
        end
        if (avg_vld) begin
            s_d.energy_result = avg; // see RULE1
            s_d.energy_calc_complete = 1'b1; // see RULE19
        end

        // Result: clear first so a same-cycle event still lands
        if (assess_result_clear) s_d.assess = ASSESS_CLEAR;
        if (tick && computing && excluded) begin
            s_d.assess = ASSESS_BUSY; // see RULE18
        end else if (avg_vld && s_d.assess != ASSESS_BUSY) begin
            s_d.assess = (avg > assess_threshold) ? ASSESS_CARRIER : ASSESS_CLEAR; // see RULE17
        end
        if (avg_vld) s_d.last_idle = (avg <= assess_threshold);

        // Idle time counts quiet intervals
        if (!assess_active) begin
            s_d.idle_elapsed_count = 10'h000;
            s_d.last_idle = 1'b0;
        end else if (tick && s_q.last_idle && s_q.idle_elapsed_count != 10'h3FF) begin
            s_d.idle_elapsed_count = s_q.idle_elapsed_count + 10'h001; // see RULE4
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.energy_control <= RST_ENERGY_CONTROL;
            s_q.gain_mid_to_low_level <= RST_GAIN_MID_TO_LOW;
            s_q.gain_low_to_mid_level <= RST_GAIN_LOW_TO_MID;
            s_q.gain_high_to_mid_level <= RST_GAIN_HIGH_TO_MID;
            s_q.gain_mid_to_high_level <= RST_GAIN_MID_TO_HIGH;
            s_q.strength_offset_middle <= RST_OFFSET_MIDDLE;
            s_q.strength_offset_low <= RST_OFFSET_LOW;
            s_q.range <= RANGE_HIGH;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state; idle_wait_expired also gated by assess_active
    assign reg_rdata = s_q.rdata;
    assign assess_result = s_q.assess;
    assign gain_range = s_q.range;
    assign energy_level = s_q.energy_result;
    assign idle_wait_expired = assess_active
                            && ({1'b0, s_q.idle_elapsed_count} >= idle_limit); // see RULE2

endmodule : edgc_core
`default_nettype wire

// file: testbench/edgc_core_assertions.sv
// Checker for the energy and gain block, bound to edgc_core.
// Assumes it sees only the core's ports; it shadows two enable bits.
`timescale 1ns/100ps
`default_nettype none
module edgc_core_assertions
    import edgc_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst_b, // Reset, active low
    input wire edgc_req_t reg_req, // Register request
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic demod_sync, // Demodulator locked
    input wire logic assess_result_clear, // Result clear pulse
    input wire logic [1:0] assess_result, // Assessment result
    input wire logic [2:0] gain_range, // One-hot gain range
    input wire logic [7:0] energy_level // Energy value
);
    logic calc_q;
    logic frz_q;

    // Shadow of the enable bits, both set at reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            calc_q <= 1'b1;
            frz_q <= 1'b1;
        end else if (reg_req.wr && reg_req.addr == OFS_ENERGY_CONTROL) begin
            calc_q <= reg_req.wdata[BIT_CALC_ON];
        end else if (reg_req.wr && reg_req.addr == OFS_GAIN_HIGH_TO_MID) begin
            frz_q <= reg_req.wdata[BIT_FREEZE_ON_SYNC];
        end
    end

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // Read of one offset, and a settled frozen lock
    sequence s_rd(logic [7:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    sequence s_locked;
        (frz_q && demod_sync) [*3];
    endsequence

    property p_rd_hold; !reg_req.rd |=> $stable(reg_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
    property p_unmapped; reg_req.rd && reg_req.addr > OFS_OFFSET_LOW |=> reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_result_rd; s_rd(OFS_ENERGY_RESULT) |=> reg_rdata == $past(energy_level); endproperty
    a_result_rd: assert property (p_result_rd) else $error("energy read differs");
    property p_ctl_rd; s_rd(OFS_ENERGY_CONTROL) ##0 !reg_req.wr |=> reg_rdata[7] == calc_q; endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("calc enable readback wrong");
    property p_onehot; $onehot(gain_range); endproperty
    a_onehot: assert property (p_onehot) else $error("gain range not one-hot");
    property p_no_jump; gain_range == RANGE_HIGH |=> gain_range != RANGE_LOW; endproperty
    a_no_jump: assert property (p_no_jump) else $error("gain skipped middle range");
    property p_freeze; s_locked |-> $stable(gain_range); endproperty
    a_freeze: assert property (p_freeze) else $error("gain moved while frozen");
    property p_busy; assess_result == ASSESS_BUSY && !assess_result_clear |=> assess_result == ASSESS_BUSY; endproperty
    a_busy: assert property (p_busy) else $error("busy result dropped");
endmodule : edgc_core_assertions

bind edgc_core edgc_core_assertions edgc_core_assertions_i (
    .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .demod_sync(demod_sync), .assess_result_clear(assess_result_clear),
    .assess_result(assess_result), .gain_range(gain_range), .energy_level(energy_level)
);
`default_nettype wire

// file: testbench/edgc_host_model.sv
// Host model: one-cycle register requests on the core's register port.
// Assumes a free-running core_clk; drives only at falling edges.
`timescale 1ns/100ps
`default_nettype none
module edgc_host_model
    import edgc_pkg::*;
(
    input wire logic core_clk, // Clock
    output var edgc_req_t reg_req, // Register request
    input wire logic [7:0] reg_rdata // Read data
);
    // No auto assessment is started, so writes never wait
    // Thresholds keep their ordered reset values
    initial begin
        reg_req = '0;
    end

    // Idle fields inverted so stale values never look valid
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr_reg

    // Data taken one edge after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge core_clk);
        d = reg_rdata;
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    endtask : rd_reg
endmodule : edgc_host_model
`default_nettype wire

// file: testbench/energy_detect_gain_control_tb.sv
// Testbench of the energy and gain block: register map, averaging, results.
// Assumes short conversion intervals set by parameter; host model drives bus.
`timescale 1ns/100ps
`default_nettype none
module energy_detect_gain_control_tb
    import edgc_pkg::*;
;
    localparam int TS = 8;
    localparam int TF = 6;
    logic core_clk, rst_b, adc_clk_fast, rx_on, demod_sync, assess_active, assess_result_clear;
    logic idle_wait_expired;
    logic [7:0] strength_raw, assess_threshold, exclusion_threshold, reg_rdata, energy_level, rd_v;
    logic [1:0] assess_result;
    logic [2:0] gain_range;
    edgc_req_t reg_req;
    int fail_count = 0, n_tests = 0, cyc = 0, e, t;
    logic [7:0] rst_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h83,
        8'h1E, 8'h03, 8'h9E, 8'h03, 8'h19, 8'h37};
    logic [4:0] n_tab [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h0F, 5'h10, 5'h08, 5'h08};

    edgc_core #(.TADC_SLOW_CYC(TS), .TADC_FAST_CYC(TF)) edgc_core_i (
        .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .adc_clk_fast(adc_clk_fast), .rx_on(rx_on), .strength_raw(strength_raw),
        .demod_sync(demod_sync), .assess_active(assess_active),
        .assess_threshold(assess_threshold), .exclusion_threshold(exclusion_threshold),
        .assess_result_clear(assess_result_clear), .assess_result(assess_result),
        .idle_wait_expired(idle_wait_expired), .gain_range(gain_range),
        .energy_level(energy_level)
    );
    edgc_host_model edgc_host_model_i (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic idle(input int k);
        repeat (k) @(negedge core_clk);
    endtask : idle

    task automatic rd(input logic [7:0] a);
        edgc_host_model_i.rd_reg(a, rd_v);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        edgc_host_model_i.wr_reg(a, d);
    endtask : wr

    // Poll completion, counting cycles
    task automatic wait_done();
        e = 0;
        rd_v = 8'h00;
        while (rd_v[BIT_CALC_COMPLETE] !== 1'b1 && e < 400) begin
            rd(OFS_ENERGY_CONTROL);
            e += 2;
        end
    endtask : wait_done

    initial begin
        rst_b = 1'b0;
        adc_clk_fast = 1'b0;
        rx_on = 1'b0;
        demod_sync = 1'b0;
        assess_active = 1'b0;
        assess_result_clear = 1'b0;
        strength_raw = 8'h10;
        assess_threshold = 8'hFF;
        exclusion_threshold = 8'hFF;
        idle(8);
        rst_b = 1'b1;
        // Reset map
        for (int i = 0; i < 12; i++) begin
            rd(OFS_ENERGY_RESULT + 8'(i));
            chk(rd_v, rst_tab[i]);
        end
        // Reserved bits, read-only writes, unmapped read
        wr(OFS_IDLE_WAIT_HIGH, 8'hFF);
        rd(OFS_IDLE_WAIT_HIGH);
        chk(rd_v, 8'hFF);
        wr(OFS_IDLE_WAIT_HIGH, 8'h00);
        wr(OFS_ENERGY_RESULT, 8'h55);
        rd(OFS_ENERGY_RESULT);
        chk(rd_v, 8'h00);
        wr(OFS_IDLE_ELAPSED_LOW, 8'h55);
        rd(OFS_IDLE_ELAPSED_LOW);
        chk(rd_v, 8'h00);
        rd(8'h40);
        chk(rd_v, 8'h00);
        // Every averaging code; code changed only with receive off
        for (int i = 0; i < 8; i++) begin
            adc_clk_fast = i[0];
            t = i[0] ? TF : TS;
            wr(OFS_ENERGY_CONTROL, 8'h80 | 8'(i));
            rx_on = 1'b1;
            wait_done();
            chk(e >= (n_tab[i] - 1) * t && e <= n_tab[i] * t + 10, 1'b1);
            rd(OFS_ENERGY_RESULT);
            chk(rd_v, 8'h10);
            chk(energy_level, 8'h10);
            rx_on = 1'b0;
            idle(2);
        end
        // Carrier, then sticky busy
        adc_clk_fast = 1'b0;
        wr(OFS_ENERGY_CONTROL, 8'h80);
        assess_threshold = 8'h0F;
        rx_on = 1'b1;
        wait_done();
        chk(assess_result, ASSESS_CARRIER);
        exclusion_threshold = 8'h0F;
        idle(3 * TS);
        chk(assess_result, ASSESS_BUSY);
        exclusion_threshold = 8'hFF;
        assess_threshold = 8'hFF;
        idle(2 * TS);
        chk(assess_result, ASSESS_BUSY);
        assess_result_clear = 1'b1;
        idle(1);
        assess_result_clear = 1'b0;
        idle(1);
        chk(assess_result, ASSESS_CLEAR);
        // Idle wait of 8 + 2 intervals
        wr(OFS_IDLE_WAIT_LOW, 8'h02);
        assess_active = 1'b1;
        e = 0;
        while (idle_wait_expired !== 1'b1 && e < 400) begin
            idle(1);
            e++;
        end
        chk(e >= 8 * TS && e <= 12 * TS + 4, 1'b1);
        rd(OFS_IDLE_ELAPSED_LOW);
        chk(rd_v >= 8'h0A && rd_v <= 8'h0B, 1'b1);
        rd(OFS_IDLE_ELAPSED_HIGH);
        chk(rd_v, 8'h00);
        assess_active = 1'b0;
        idle(2);
        chk(idle_wait_expired, 1'b0);
        // Gain freeze, then switching
        demod_sync = 1'b1;
        strength_raw = 8'hFF;
        idle(4 * TS);
        chk(gain_range, RANGE_HIGH);
        demod_sync = 1'b0;
        idle(4 * TS);
        chk(gain_range !== RANGE_HIGH, 1'b1);
        strength_raw = 8'h00;
        idle(20 * TS);
        chk(gain_range, RANGE_HIGH);
        wr(OFS_GAIN_HIGH_TO_MID, 8'h1E);
        demod_sync = 1'b1;
        strength_raw = 8'hFF;
        idle(4 * TS);
        chk(gain_range !== RANGE_HIGH, 1'b1);
        // Computation off: no completion
        rx_on = 1'b0;
        wr(OFS_ENERGY_CONTROL, 8'h00);
        rx_on = 1'b1;
        idle(4 * TS);
        rd(OFS_ENERGY_CONTROL);
        chk(rd_v, 8'h00);
        stop_test();
    end
endmodule : energy_detect_gain_control_tb
`default_nettype wire
